// ---- rtl/psram_dev_pkg.sv ----
// psram_dev_pkg: shared types, register layout and timing constants for the
// octal ddr pseudo-static ram device model.
// assumes a single 250 mhz system clock and an ahb-lite register slave.
//
// Summary of operation
// - burst-type config bit 0 selects hybrid wrapping, 1 selects plain repeating wrap.
// - latency code 0000..0011 gives 5..8 clocks, 1110 gives 3, 1111 gives 4.
// - hybrid wrap: wrap once through group from start, then linear from next group.
// - wrap codes repeat within aligned 128, 64, 16 or 32 byte groups.
// - command linear bit set gives incrementing word addresses, ignoring burst code.
// - memory reads, writes and register reads wait the configured initial latency.
// - initial latency defaults to 6 clocks after reset.
// - pending refresh at transaction start drives strobe high and doubles latency.
// - register writes have no latency; data captured right after command phase.
// - register write data position ignores the strobe level shown in command phase.
// - array refresh may run alongside register write capture without delaying it.
// - fixed-latency bit set always drives strobe high and doubles latency.
// - fixed-latency bit is set after reset.
// - fixed-latency bit clear gives variable latency, strobe high only for refresh.
// - drive-strength field selects data pin impedance, resets to 000.
// - writing 0 to power-down bit enters deep power-down in time; refresh stops.
// - array contents are invalid after deep power-down.
// - deep power-down exits on chip select low then high, or on reset.
package psram_dev_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_CMD = 3'b001,
		ST_LAT = 3'b010,
		ST_RD = 3'b011,
		ST_WR = 3'b100,
		ST_REGWR = 3'b101,
		ST_DONE = 3'b110
	} state_t;

	// configuration register zero layout, msb first
	typedef struct packed {
		logic pd;
		logic [2:0] drv;
		logic [3:0] rsv;
		logic [3:0] lat;
		logic fixed;
		logic legacy;
		logic [1:0] blen;
	} cfg0_t;

	// link pins as seen by the sampler
	typedef struct packed {
		logic cs_n;
		logic ck;
		logic strobe;
		logic [7:0] dq;
	} link_in_t;

	localparam link_in_t LINK_IDLE = 11'h400;
	localparam logic [15:0] CFG0_RESET = 16'h8F1F;
	localparam logic [3:0] CFG0_RSV_ONES = 4'hF;
	localparam logic [2:0] DRV_RESET = 3'h0;
	localparam logic [3:0] LAT_DEFAULT_CLK = 4'h6;

	localparam logic [1:0] BL_128 = 2'h0;
	localparam logic [1:0] BL_64 = 2'h1;
	localparam logic [1:0] BL_16 = 2'h2;
	localparam logic [1:0] BL_32 = 2'h3;
	localparam logic [31:0] MASK_128 = 32'h0000003F;
	localparam logic [31:0] MASK_64 = 32'h0000001F;
	localparam logic [31:0] MASK_16 = 32'h00000007;
	localparam logic [31:0] MASK_32 = 32'h0000000F;
	localparam int GROUP_MAX_BITS = 6;
	localparam int GROUP_MIN_BITS = 3;

	// command-address word fields
	localparam logic [2:0] CMD_LAST = 3'h5;
	localparam int CMD_RW_BIT = 47;
	localparam int CMD_REG_BIT = 46;
	localparam int CMD_LIN_BIT = 45;
	localparam int CMD_ROW_HI = 44;
	localparam int CMD_ROW_LO = 16;
	localparam int CMD_COL_HI = 2;

	// timing
	localparam int SYS_MHZ = 250;
	localparam int REFR_INT_NS = 4000;
	localparam int REFR_CYC = (REFR_INT_NS * SYS_MHZ) / 1000;

	// register slave map
	localparam logic [31:0] OFF_CTRL = 32'h00000000;
	localparam logic [31:0] OFF_STATUS = 32'h00000004;
	localparam logic [31:0] OFF_CFG0 = 32'h00000008;
	localparam int CTRL_REFR_EN = 0;
	localparam int STS_PDN = 0;
	localparam int STS_EXIT = 1;
	localparam int STS_PEND = 2;
	localparam int STS_RBUSY = 3;
	localparam int STS_VALID = 4;
	localparam int STS_ACTIVE = 5;

	// latency code to clock count, reserved codes fall back to the default
	function automatic logic [3:0] lat_clocks(input logic [3:0] code);
		case (code)
			4'h0: lat_clocks = 4'h5;
			4'h1: lat_clocks = 4'h6;
			4'h2: lat_clocks = 4'h7;
			4'h3: lat_clocks = 4'h8;
			4'hE: lat_clocks = 4'h3;
			4'hF: lat_clocks = 4'h4;
			default: lat_clocks = LAT_DEFAULT_CLK;
		endcase
	endfunction : lat_clocks
endpackage : psram_dev_pkg

// ---- rtl/link_sampler.sv ----
// link_sampler: brings chip select, bus clock, strobe and data into CLK_SYS.
// assumes the bus clock is far slower than CLK_SYS so every edge is seen.
`timescale 1ns/1ns
module link_sampler (
	input wire logic clk,
	input wire logic rst,
	input psram_dev_pkg::link_in_t raw,
	output psram_dev_pkg::link_in_t sync,
	output logic ck_edge,
	output logic cs_rise
);
	psram_dev_pkg::link_in_t s1_r;
	psram_dev_pkg::link_in_t s2_r;
	logic ck_d_r;
	logic cs_d_r;

	// two-stage synchroniser; data shares the clock's delay so alignment holds
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_r <= psram_dev_pkg::LINK_IDLE;
			s2_r <= psram_dev_pkg::LINK_IDLE;
			ck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
		end else begin
			s1_r <= raw;
			s2_r <= s1_r;
			ck_d_r <= s2_r.ck;
			cs_d_r <= s2_r.cs_n;
		end
	end

	// both clock edges carry a byte, ddr
	assign sync = s2_r;
	assign ck_edge = s2_r.ck ^ ck_d_r;
	assign cs_rise = s2_r.cs_n & ~cs_d_r;
endmodule : link_sampler

// ---- rtl/burst_addr_step.sv ----
// burst_addr_step: next word address of a burst for wrap, hybrid and linear.
// assumes the caller steps once per 16-bit word and holds the start address.
`timescale 1ns/1ns
module burst_addr_step (
	input wire logic [31:0] cur,
	input wire logic [31:0] start,
	input wire logic linear,
	input wire logic legacy,
	input wire logic [1:0] blen,
	input wire logic done,
	output logic [31:0] next,
	output logic done_nxt
);
	logic [31:0] mask;
	logic [31:0] wrapped;

	// group size in words is half the byte length
	always_comb begin
		case (blen)
			psram_dev_pkg::BL_128: mask = psram_dev_pkg::MASK_128;
			psram_dev_pkg::BL_64: mask = psram_dev_pkg::MASK_64;
			psram_dev_pkg::BL_16: mask = psram_dev_pkg::MASK_16;
			default: mask = psram_dev_pkg::MASK_32;
		endcase
		wrapped = (cur & ~mask) | ((cur + 32'h00000001) & mask);
		next = wrapped;
		done_nxt = done;
		if (linear || done) begin
			next = cur + 32'h00000001;
		end else if (!legacy && wrapped == start) begin
			next = (start | mask) + 32'h00000001;
			done_nxt = 1'b1;
		end
	end
endmodule : burst_addr_step

// ---- rtl/psram_octal_dev.sv ----
// psram_octal_dev: device side of a ddr octal pseudo-static ram with
// configuration register zero, refresh latency signalling and deep power-down.
// assumes the host drives CS_N, CK and DQ, with CK slow against CLK_SYS.
`timescale 1ns/1ns
module psram_octal_dev #(
	parameter int MEM_WORDS = 64,
	parameter int PDN_IN_NS = 1000,
	parameter int PDN_OUT_NS = 2000,
	parameter int REFR_BUSY_CYC = 20
) (
	input wire logic CLK_SYS,
	input wire logic SRST,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	input wire logic CS_N,
	input wire logic CK,
	input wire logic [7:0] DQ_IN,
	input wire logic STROBE_IN,
	output logic [7:0] DQ_OUT,
	output logic DQ_OE,
	output logic STROBE_OUT,
	output logic STROBE_OE,
	output logic [2:0] DRIVE_STRENGTH
);
	localparam int IDX_W = $clog2(MEM_WORDS);
	localparam int PDN_IN_RAW = (PDN_IN_NS * psram_dev_pkg::SYS_MHZ) / 1000;
	localparam int PDN_OUT_RAW = (PDN_OUT_NS * psram_dev_pkg::SYS_MHZ) / 1000;
	localparam int PDN_IN_CYC = (PDN_IN_RAW < 1) ? 1 : PDN_IN_RAW;
	localparam int PDN_OUT_CYC = (PDN_OUT_RAW < 1) ? 1 : PDN_OUT_RAW;
	localparam int PDN_IN_BOUND = PDN_IN_CYC + 1;

	psram_dev_pkg::link_in_t ls;
	psram_dev_pkg::state_t state_r;
	psram_dev_pkg::cfg0_t cfg0_r;
	logic ck_edge;
	logic cs_rise;
	logic [39:0] cmd_r;
	logic [47:0] cmd_full;
	logic [31:0] cmd_word;
	logic [2:0] cmd_cnt_r;
	logic [5:0] lat_cnt_r;
	logic [5:0] lat_edges;
	logic [3:0] lat_clk;
	logic byte_hi_r;
	logic [31:0] addr_r;
	logic [31:0] start_r;
	logic [31:0] addr_nxt;
	logic done_nxt;
	logic linear_r;
	logic wrap_done_r;
	logic rd_r;
	logic reg_r;
	logic dbl_r;
	logic [7:0] wr_hi_r;
	logic [7:0] dq_out_r;
	logic dq_oe_r;
	logic strobe_out_r;
	logic strobe_oe_r;
	logic [15:0] mem_r [MEM_WORDS];
	logic [15:0] rd_word;
	logic [15:0] cfg0_bits;
	logic step;
	logic cmd_end;
	logic cmd_regwr;
	logic absorb;
	logic reg_we;
	logic [15:0] reg_wdata;
	logic mem_we;
	logic addr_step;
	logic pwr_busy;
	logic [15:0] rtim_r;
	logic [15:0] rcnt_r;
	logic pend_r;
	logic rbusy_r;
	logic refr_tick;
	logic refr_idle_ok;
	logic entering_r;
	logic pdn_r;
	logic exiting_r;
	logic [15:0] pcnt_r;
	logic exit_done;
	logic array_valid_r;
	logic refr_en_r;
	logic dwr_r;
	logic [31:0] daddr_r;
	logic [31:0] hrdata_r;
	logic hready_r;
	logic hresp_r;
	logic ahb_go;
	logic [31:0] rd_mux;

	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (SRST);

	link_sampler u_sampler (
		.clk(CLK_SYS),
		.rst(SRST),
		.raw({CS_N, CK, STROBE_IN, DQ_IN}),
		.sync(ls),
		.ck_edge(ck_edge),
		.cs_rise(cs_rise)
	);

	burst_addr_step u_step (
		.cur(addr_r),
		.start(start_r),
		.linear(linear_r),
		.legacy(cfg0_r.legacy),
		.blen(cfg0_r.blen),
		.done(wrap_done_r),
		.next(addr_nxt),
		.done_nxt(done_nxt)
	);

	// command decode and latency length
	assign cmd_full = {cmd_r, ls.dq};
	assign cmd_word = {cmd_full[psram_dev_pkg::CMD_ROW_HI:psram_dev_pkg::CMD_ROW_LO],
		cmd_full[psram_dev_pkg::CMD_COL_HI:0]};
	assign cmd_regwr = cmd_full[psram_dev_pkg::CMD_REG_BIT] && !cmd_full[psram_dev_pkg::CMD_RW_BIT];
	assign lat_clk = psram_dev_pkg::lat_clocks(cfg0_r.lat);
	assign lat_edges = dbl_r ? {lat_clk, 2'b00} : {1'b0, lat_clk, 1'b0};
	assign pwr_busy = pdn_r || exiting_r;
	assign step = ck_edge && !ls.cs_n && !pwr_busy;
	assign cmd_end = step && state_r == psram_dev_pkg::ST_CMD && cmd_cnt_r == psram_dev_pkg::CMD_LAST;
	assign absorb = cmd_end && dbl_r && !cmd_regwr;
	assign reg_we = step && state_r == psram_dev_pkg::ST_REGWR && !byte_hi_r;
	assign reg_wdata = {wr_hi_r, ls.dq};
	assign mem_we = step && state_r == psram_dev_pkg::ST_WR && !ls.strobe;
	assign addr_step = step && !byte_hi_r && (state_r == psram_dev_pkg::ST_RD || state_r == psram_dev_pkg::ST_WR);
	assign cfg0_bits = cfg0_r;
	assign rd_word = reg_r ? cfg0_bits : mem_r[addr_r[IDX_W-1:0]];

	// link sequencer: command phase, latency, then data; chip select high ends all
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			state_r <= psram_dev_pkg::ST_IDLE;
			cmd_r <= '0;
			cmd_cnt_r <= '0;
			lat_cnt_r <= '0;
			byte_hi_r <= 1'b1;
			addr_r <= '0;
			start_r <= '0;
			linear_r <= 1'b0;
			wrap_done_r <= 1'b0;
			rd_r <= 1'b0;
			reg_r <= 1'b0;
			dbl_r <= 1'b0;
			wr_hi_r <= '0;
			dq_out_r <= '0;
			dq_oe_r <= 1'b0;
			strobe_out_r <= 1'b0;
			strobe_oe_r <= 1'b0;
		end else if (ls.cs_n || pwr_busy) begin
			state_r <= psram_dev_pkg::ST_IDLE;
			dq_oe_r <= 1'b0;
			strobe_oe_r <= 1'b0;
			strobe_out_r <= 1'b0;
		end else begin
			case (state_r)
				psram_dev_pkg::ST_IDLE: begin
					state_r <= psram_dev_pkg::ST_CMD;
					cmd_cnt_r <= '0;
					byte_hi_r <= 1'b1;
					dbl_r <= cfg0_r.fixed || pend_r;
					strobe_out_r <= cfg0_r.fixed || pend_r;
					strobe_oe_r <= 1'b1;
				end
				psram_dev_pkg::ST_CMD: if (ck_edge) begin
					cmd_r <= cmd_full[39:0];
					cmd_cnt_r <= cmd_cnt_r + 3'h1;
					if (cmd_cnt_r == psram_dev_pkg::CMD_LAST) begin
						addr_r <= cmd_word;
						start_r <= cmd_word;
						linear_r <= cmd_full[psram_dev_pkg::CMD_LIN_BIT];
						wrap_done_r <= 1'b0;
						rd_r <= cmd_full[psram_dev_pkg::CMD_RW_BIT];
						reg_r <= cmd_full[psram_dev_pkg::CMD_REG_BIT];
						strobe_out_r <= 1'b0;
						strobe_oe_r <= cmd_full[psram_dev_pkg::CMD_RW_BIT];
						lat_cnt_r <= lat_edges;
						// register writes skip latency whatever the strobe showed
						state_r <= cmd_regwr ? psram_dev_pkg::ST_REGWR : psram_dev_pkg::ST_LAT;
					end
				end
				psram_dev_pkg::ST_LAT: if (ck_edge) begin
					lat_cnt_r <= lat_cnt_r - 6'h01;
					if (lat_cnt_r == 6'h01) begin
						state_r <= rd_r ? psram_dev_pkg::ST_RD : psram_dev_pkg::ST_WR;
					end
				end
				psram_dev_pkg::ST_RD: if (ck_edge) begin
					dq_out_r <= byte_hi_r ? rd_word[15:8] : rd_word[7:0];
					dq_oe_r <= 1'b1;
					strobe_out_r <= byte_hi_r;
					byte_hi_r <= ~byte_hi_r;
					if (!byte_hi_r) begin
						addr_r <= addr_nxt;
						wrap_done_r <= done_nxt;
					end
				end
				psram_dev_pkg::ST_WR: if (ck_edge) begin
					byte_hi_r <= ~byte_hi_r;
					if (!byte_hi_r) begin
						addr_r <= addr_nxt;
						wrap_done_r <= done_nxt;
					end
				end
				psram_dev_pkg::ST_REGWR: if (ck_edge) begin
					byte_hi_r <= 1'b0;
					if (byte_hi_r) begin
						wr_hi_r <= ls.dq;
					end else begin
						state_r <= psram_dev_pkg::ST_DONE;
					end
				end
				default: begin
					state_r <= state_r;
				end
			endcase
		end
	end

	// array storage, strobe high masks the byte
	always_ff @(posedge CLK_SYS) begin
		if (mem_we) begin
			if (byte_hi_r) begin
				mem_r[addr_r[IDX_W-1:0]][15:8] <= ls.dq;
			end else begin
				mem_r[addr_r[IDX_W-1:0]][7:0] <= ls.dq;
			end
		end
	end

	// configuration register zero; reserved bits always read as ones
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			cfg0_r <= psram_dev_pkg::CFG0_RESET;
		end else if (reg_we) begin
			cfg0_r <= reg_wdata;
			cfg0_r.rsv <= psram_dev_pkg::CFG0_RSV_ONES;
		end else if (exit_done) begin
			cfg0_r.pd <= 1'b1;
		end
	end

	// distributed refresh: tick sets pending, set wins over any clear
	assign refr_tick = refr_en_r && rtim_r == 16'(psram_dev_pkg::REFR_CYC - 1);
	assign refr_idle_ok = state_r == psram_dev_pkg::ST_IDLE || state_r == psram_dev_pkg::ST_REGWR
		|| state_r == psram_dev_pkg::ST_DONE;
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			rtim_r <= '0;
			rcnt_r <= '0;
			pend_r <= 1'b0;
			rbusy_r <= 1'b0;
		end else if (pdn_r) begin
			rtim_r <= '0;
			rcnt_r <= '0;
			pend_r <= 1'b0;
			rbusy_r <= 1'b0;
		end else begin
			rtim_r <= (refr_tick || !refr_en_r) ? 16'h0000 : rtim_r + 16'h0001;
			if (refr_tick) begin
				pend_r <= 1'b1;
			end else if (absorb || (rbusy_r && rcnt_r == 16'(REFR_BUSY_CYC - 1))) begin
				pend_r <= 1'b0;
			end
			if (absorb || (rbusy_r && rcnt_r == 16'(REFR_BUSY_CYC - 1))) begin
				rbusy_r <= 1'b0;
				rcnt_r <= '0;
			end else if (rbusy_r) begin
				rcnt_r <= rcnt_r + 16'h0001;
			end else if (pend_r && refr_idle_ok) begin
				rbusy_r <= 1'b1;
			end
		end
	end

	// deep power-down entry, stay, and exit timers
	assign exit_done = exiting_r && pcnt_r == 16'(PDN_OUT_CYC - 1);
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			entering_r <= 1'b0;
			pdn_r <= 1'b0;
			exiting_r <= 1'b0;
			pcnt_r <= '0;
			array_valid_r <= 1'b1;
		end else if (entering_r) begin
			pcnt_r <= pcnt_r + 16'h0001;
			if (pcnt_r == 16'(PDN_IN_CYC - 1)) begin
				entering_r <= 1'b0;
				pdn_r <= 1'b1;
				array_valid_r <= 1'b0;
				pcnt_r <= '0;
			end
		end else if (pdn_r) begin
			if (cs_rise) begin
				pdn_r <= 1'b0;
				exiting_r <= 1'b1;
			end
		end else if (exiting_r) begin
			// host must not start a transaction until this runs out
			pcnt_r <= exit_done ? 16'h0000 : pcnt_r + 16'h0001;
			exiting_r <= !exit_done;
		end else if (reg_we && !reg_wdata[15] && cfg0_r.pd) begin
			entering_r <= 1'b1;
		end
	end

	// ahb-lite slave, zero wait states, always OKAY
	assign ahb_go = HSEL && HTRANS[1] && HREADY;
	always_comb begin
		case (HADDR)
			psram_dev_pkg::OFF_CTRL: rd_mux = {31'h00000000, refr_en_r};
			psram_dev_pkg::OFF_STATUS: rd_mux = {26'h0000000, state_r != psram_dev_pkg::ST_IDLE,
				array_valid_r, rbusy_r, pend_r, exiting_r, pdn_r};
			psram_dev_pkg::OFF_CFG0: rd_mux = {16'h0000, cfg0_bits};
			default: rd_mux = 32'h00000000;
		endcase
	end
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			dwr_r <= 1'b0;
			daddr_r <= '0;
			hrdata_r <= '0;
			hready_r <= 1'b1;
			hresp_r <= 1'b0;
		end else begin
			dwr_r <= ahb_go && HWRITE;
			daddr_r <= HADDR;
			hready_r <= 1'b1;
			hresp_r <= 1'b0;
			if (ahb_go && !HWRITE) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	// refresh enable from software steers the refresh timer
	always_ff @(posedge CLK_SYS) begin
		if (SRST) begin
			refr_en_r <= 1'b1;
		end else if (dwr_r && daddr_r == psram_dev_pkg::OFF_CTRL) begin
			refr_en_r <= HWDATA[psram_dev_pkg::CTRL_REFR_EN];
		end
	end

	assign HRDATA = hrdata_r;
	assign HREADYOUT = hready_r;
	assign HRESP = hresp_r;
	assign DQ_OUT = dq_out_r;
	assign DQ_OE = dq_oe_r;
	assign STROBE_OUT = strobe_out_r;
	assign STROBE_OE = strobe_oe_r;
	assign DRIVE_STRENGTH = cfg0_r.drv;

	latency_default_a: assert property ($fell(SRST) |-> lat_clk == psram_dev_pkg::LAT_DEFAULT_CLK)
		else $error("initial latency not default after reset");
	fixed_default_a: assert property ($fell(SRST) |-> cfg0_r.fixed && cfg0_r.pd)
		else $error("fixed latency not set after reset");
	drive_reset_a: assert property ($fell(SRST) |-> DRIVE_STRENGTH == psram_dev_pkg::DRV_RESET)
		else $error("drive strength not reset value");
	cmd_strobe_a: assert property ($rose(state_r == psram_dev_pkg::ST_CMD) |->
		STROBE_OE && STROBE_OUT == ($past(cfg0_r.fixed) || $past(pend_r)) && dbl_r == STROBE_OUT)
		else $error("strobe in command phase does not match latency need");
	lat_load_a: assert property (cmd_end && !cmd_regwr |=>
		state_r == psram_dev_pkg::ST_LAT && lat_cnt_r == $past(lat_edges))
		else $error("latency count loaded wrongly");
	regwr_capture_a: assert property (reg_we |=> cfg0_r[7:0] == $past(ls.dq))
		else $error("register write data not captured");
	regwr_nolat_a: assert property (cmd_end && cmd_regwr |=> state_r == psram_dev_pkg::ST_REGWR)
		else $error("register write delayed by latency");
	wrap_fixed_a: assert property (addr_step && !linear_r && cfg0_r.legacy |->
		addr_nxt[31:psram_dev_pkg::GROUP_MAX_BITS] == addr_r[31:psram_dev_pkg::GROUP_MAX_BITS])
		else $error("wrap left its group");
	linear_a: assert property (addr_step && linear_r |-> addr_nxt == addr_r + 32'h00000001)
		else $error("linear burst not incrementing");
	hybrid_jump_a: assert property (addr_step && !linear_r && !cfg0_r.legacy && !wrap_done_r && done_nxt
		|-> addr_nxt[psram_dev_pkg::GROUP_MIN_BITS-1:0] == 3'h0 && addr_nxt > start_r)
		else $error("hybrid burst did not move to next group");
	pdn_entry_a: assert property ($rose(entering_r) |-> ##[1:PDN_IN_BOUND] pdn_r)
		else $error("deep power-down entry too slow");
	refresh_stop_a: assert property (pdn_r && $past(pdn_r) |-> !pend_r && !rbusy_r)
		else $error("refresh active in deep power-down");
	array_invalid_a: assert property (pdn_r |-> !array_valid_r)
		else $error("array still valid in deep power-down");
	pdn_exit_a: assert property (pdn_r && cs_rise |=> exiting_r && !pdn_r)
		else $error("chip select pulse did not start exit");
endmodule : psram_octal_dev

// ---- verif/host_link_model.sv ----
// host_link_model: host controller side of the octal ddr link
// assumes the bench resolves the shared data and strobe wires from both enables
`timescale 1ns/1ns
module host_link_model (
	input wire logic clk,
	output logic cs_n,
	output logic ck,
	output logic [7:0] dq,
	output logic strobe,
	input wire logic [7:0] dq_w,
	input wire logic strobe_w
);
	// link idle, bus clock low
	initial begin
		cs_n = 1'b1;
		ck = 1'b0;
		dq = 8'h00;
		strobe = 1'b0;
	end

	// one ddr edge every 10 system cycles, data changed mid-way between edges
	task automatic xfer(input logic [47:0] cmd, input int lat, input int nb, input logic [7:0] wb[$],
		output logic dbl, output logic [7:0] rb[$]);
		int e;
		int tot;
		int p;
		logic wr;
		rb = {};
		wr = !cmd[47];
		dbl = 1'b0;
		tot = 6 + nb + ((wr && cmd[46]) ? 0 : 4 * lat);
		e = 0;
		cs_n <= 1'b0;
		while (e < tot) begin
			p = e - (tot - nb);
			// lines nobody drives show a changing pattern, not the last value
			dq <= (e < 6) ? cmd[47 - 8 * e -: 8] : ((wr && p >= 0) ? wb[p] : ~dq);
			strobe <= (wr && p >= 0) ? 1'b0 : ~strobe;
			repeat (5) @(posedge clk);
			ck <= ~ck;
			repeat (5) @(posedge clk);
			if (e == 3) begin
				dbl = strobe_w;
				if (!(wr && cmd[46]) && strobe_w !== 1'b1) tot = tot - 2 * lat;
			end
			if (!wr && p >= 0) rb.push_back(dq_w);
			e = e + 1;
		end
		repeat (5) @(posedge clk);
		cs_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : xfer
endmodule : host_link_model

// ---- verif/psram_burst_latency_power_ctrl_bench.sv ----
// psram_burst_latency_power_ctrl_bench: register bus and link scenarios for the octal ram device
// assumes the design package is compiled first and host_link_model drives the link
`timescale 1ns/1ns
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t: got %h exp %h", $time, g, e); end end
module psram_burst_latency_power_ctrl_bench;
	logic clk;
	logic srst = 1'b1;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic hready;
	logic hresp;
	logic cs_n, ck, h_strobe, dq_oe, strobe_out, strobe_oe, dbl;
	logic [7:0] h_dq, dq_out;
	logic [2:0] drv;
	logic [31:0] r;
	logic [7:0] rb[$];
	logic [7:0] wb[$];
	logic [3:0] codes[6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hE, 4'hF};
	int clks[6] = '{5, 6, 7, 8, 3, 4};
	int error_cnt = 0;
	int cmp_count = 0;

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// short power-down times keep the run brief
	psram_octal_dev #(.PDN_IN_NS(160), .PDN_OUT_NS(160)) u_psram_octal_dev (.CLK_SYS(clk), .SRST(srst),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
		.HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .CS_N(cs_n), .CK(ck),
		.DQ_IN(dq_oe ? dq_out : h_dq), .STROBE_IN(strobe_oe ? strobe_out : h_strobe), .DQ_OUT(dq_out),
		.DQ_OE(dq_oe), .STROBE_OUT(strobe_out), .STROBE_OE(strobe_oe), .DRIVE_STRENGTH(drv));
	host_link_model u_host_link_model (.clk(clk), .cs_n(cs_n), .ck(ck), .dq(h_dq), .strobe(h_strobe),
		.dq_w(dq_oe ? dq_out : h_dq), .strobe_w(strobe_oe ? strobe_out : h_strobe));

	task automatic give_verdict();
		$display("errors %0d compares %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : give_verdict

	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			error_cnt++;
			give_verdict();
		end
	endtask : wait_rdy

	// single word transfer; each phase held until ready is sampled high
	task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		wait_rdy();
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		r = hrdata;
		`CHK(hresp, 1'b0)
	endtask : ahb

	// status polling is bounded; running out ends the run
	task automatic poll(input logic [31:0] m, input logic v, input int lim);
		int n;
		n = 0;
		do begin
			ahb(1'b0, 32'h00000004, 32'h0);
			n++;
		end while ((|(r & m)) !== v && n < lim);
		`CHK(|(r & m), v)
		if ((|(r & m)) !== v) give_verdict();
	endtask : poll

	task automatic lnk(input logic rw, input logic rg, input logic ln, input logic [31:0] a, input int lat,
		input int nb);
		u_host_link_model.xfer({rw, rg, ln, a[31:3], 13'h0, a[2:0]}, lat, nb, wb, dbl, rb);
	endtask : lnk

	function automatic logic [15:0] wv(input int x);
		wv = {2'h2, x[5:0], 2'h1, x[5:0]};
	endfunction : wv

	initial begin
		int i;
		int k;
		int gw;
		int b;
		int x;
		logic [15:0] c;
		repeat (12) @(posedge clk);
		srst <= 1'b0;
		ahb(1'b0, 32'h00000008, 32'h0);
		`CHK(r, 32'h00008F1F)
		`CHK(drv, 3'h0)
		ahb(1'b0, 32'h00000040, 32'h0);
		`CHK(r, 32'h0)
		ahb(1'b1, 32'h00000000, 32'h0);
		// fill the array with address-derived words
		wb = {};
		for (i = 0; i < 64; i++) begin
			c = wv(i);
			wb.push_back(c[15:8]);
			wb.push_back(c[7:0]);
		end
		lnk(1'b0, 1'b0, 1'b1, 32'h0, 6, 128);
		`CHK(dbl, 1'b1)
		// each of the six defined latency codes, read back through the register space
		for (i = 0; i < 6; i++) begin
			c = {8'hD0, codes[i], 4'h7};
			wb = {c[15:8], c[7:0]};
			lnk(1'b0, 1'b1, 1'b0, 32'h0, 0, 2);
			c[11:8] = 4'hF;
			ahb(1'b0, 32'h00000008, 32'h0);
			`CHK(r, {16'h0, c})
			lnk(1'b1, 1'b1, 1'b0, 32'h0, clks[i], 2);
			`CHK(dbl, 1'b0)
			`CHK({rb[0], rb[1]}, c)
		end
		`CHK(drv, 3'h5)
		// all group sizes, wrap and hybrid, then a linear burst
		for (i = 0; i < 9; i++) begin
			c = {8'hD0, 4'hF, 1'b0, i[2], i[1:0]};
			wb = {c[15:8], c[7:0]};
			lnk(1'b0, 1'b1, 1'b0, 32'h0, 0, 2);
			lnk(1'b1, 1'b0, i == 8, 32'h0000003D, 4, 40);
			gw = (i[1:0] == 2'h2) ? 8 : ((i[1:0] == 2'h3) ? 16 : (64 >> i[1:0]));
			b = 61 & ~(gw - 1);
			for (k = 0; k < 20; k++) begin
				x = (i == 8) ? 61 + k : ((i[2] || k < gw) ? b + (61 - b + k) % gw : b + k);
				`CHK({rb[2 * k], rb[2 * k + 1]}, wv(x & 63))
			end
		end
		// a refresh waiting or running when a read starts doubles the latency
		ahb(1'b1, 32'h00000000, 32'h1);
		poll(32'h0000000C, 1'b1, 800);
		lnk(1'b1, 1'b1, 1'b0, 32'h0, 4, 2);
		`CHK(dbl, 1'b1)
		wb = {8'h50, 8'hF7};
		lnk(1'b0, 1'b1, 1'b0, 32'h0, 0, 2);
		poll(32'h00000001, 1'b1, 30);
		`CHK(r[4], 1'b0)
		lnk(1'b1, 1'b1, 1'b0, 32'h0, 4, 2);
		poll(32'h00000003, 1'b0, 100);
		ahb(1'b0, 32'h00000008, 32'h0);
		`CHK(r[15], 1'b1)
		give_verdict();
	end
endmodule : psram_burst_latency_power_ctrl_bench
